// ### src/ebg_dm_ram.v
// Purpose: On-chip data RAM, 2K words of 16 bits.
// Assumes: Single port, write and registered read in one clock.
// Notes:   No reset on the array; contents are undefined after power-up.
`timescale 1ns/100ps
`default_nettype none
`include "ebg_regs.vh"
module ebg_dm_ram (
   input  wire         i_core_clk,
   input  wire         i_we,
   input  wire [10:0]  i_addr,
   input  wire [15:0]  i_wdata,
   output reg  [15:0]  o_rdata
);
   reg [15:0] mem [0:`EBG_RAM_WORDS-1];
   always @(posedge i_core_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule
`default_nettype wire

// ### src/ebg_port.v
// Purpose: Data memory port with hold request, hold acknowledge and grant-hang.
// Assumes: Core presents one request at a time and holds it until o_core_ack.
// Notes:   Reset loads the configuration defaults and the sequencer outputs; a hold request is still granted.
`timescale 1ns/100ps
`default_nettype none
`include "ebg_regs.vh"
module ebg_port (
   input  wire         i_core_clk,
   input  wire         i_rst_n,
   input  wire         i_core_req,
   input  wire         i_core_wr,
   input  wire [13:0]  i_core_addr,
   input  wire [15:0]  i_core_wdata,
   input  wire         i_core_pair,
   output reg          o_core_ack,
   output reg  [15:0]  o_core_rdata,
   output reg          o_core_run,
   input  wire         i_hold_request_n,
   output reg          o_hold_acknowledge_n,
   output reg          o_grant_hang_n,
   output reg  [13:0]  o_addr,
   output reg          o_addr_oe,
   input  wire [23:0]  i_dm_data_bus,
   output reg  [23:0]  o_dm_data_bus,
   output reg          o_dm_data_bus_oe,
   output reg          o_data_space_select_n,
   output reg          o_program_space_select_n,
   output reg          o_boot_space_select_n,
   output reg          o_rd_n,
   output reg          o_wr_n,
   output reg          o_ctl_oe,
   output reg  [2:0]   o_wait_zone0,
   output reg          o_go_mode
);
   // ****************************************************************
   // Decoding
   // ****************************************************************
   localparam ST_IDLE  = 2'd0;
   localparam ST_EXT   = 2'd1;
   localparam ST_DONE  = 2'd2;
   localparam ST_GRANT = 2'd3;

   function [1:0] zone_of;
      input [13:0] a;
      begin
         if (a < `EBG_ZONE1_BASE)
            zone_of = 2'd0;
         else if (a < `EBG_ZONE2_BASE)
            zone_of = 2'd1;
         else
            zone_of = 2'd2;
      end
   endfunction

   function is_ram;
      input [13:0] a;
      begin
         is_ram = (a >= `EBG_RAM_BASE) && (a < `EBG_CTRL_BASE);
      end
   endfunction

   function is_ctl;
      input [13:0] a;
      begin
         is_ctl = (a >= `EBG_CTRL_BASE);
      end
   endfunction

   reg  [1:0]  state_q;
   reg  [2:0]  wcnt_q;
   reg  [15:0] wait_q;
   reg  [15:0] sys_q;
   reg         int_busy_q;
   reg  [10:0] ram_addr;
   wire [15:0] ram_rdata;
   wire        hold_req = ~i_hold_request_n;
   wire        ext_req  = i_core_req & ~is_ram(i_core_addr) & ~is_ctl(i_core_addr);
   wire        int_req  = i_core_req & ~ext_req;
   wire        ram_we   = int_req & ~int_busy_q & i_core_wr & is_ram(i_core_addr);
   reg  [2:0]  zone_wait;

   // ****************************************************************
   // Internal RAM and control registers
   // ****************************************************************
   always @* begin
      ram_addr = i_core_addr[10:0];
      case (zone_of(i_core_addr))
         2'd0:    zone_wait = wait_q[`EBG_WZ0_LSB+2:`EBG_WZ0_LSB];
         2'd1:    zone_wait = wait_q[`EBG_WZ1_LSB+2:`EBG_WZ1_LSB];
         default: zone_wait = wait_q[`EBG_WZ2_LSB+2:`EBG_WZ2_LSB];
      endcase
      // Fields above bit 8 are kept for software but never select a zone.
   end

   ebg_dm_ram u_ram (
      .i_core_clk (i_core_clk),
      .i_we       (ram_we),
      .i_addr     (ram_addr),
      .i_wdata    (i_core_wdata),
      .o_rdata    (ram_rdata)
   );

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_q       <= `EBG_WAIT_RESET;
         sys_q        <= `EBG_SYS_RESET;
         int_busy_q   <= 1'b0;
      end else begin
         int_busy_q <= int_req & ~int_busy_q;
         if (int_req & ~int_busy_q & i_core_wr) begin
            if (i_core_addr == `EBG_WAIT_REG)
               wait_q <= i_core_wdata & `EBG_WAIT_MASK;
            else if (i_core_addr == `EBG_SYS_REG)
               sys_q <= i_core_wdata & `EBG_SYS_MASK;
         end
      end
   end

   // ****************************************************************
   // External access and bus grant sequencer
   // ****************************************************************
   // The sequencer resets synchronously so that a hold request is still granted
   // while reset is held; an async reset branch could only load constants.
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_q                  <= ST_IDLE;
         wcnt_q                   <= 3'd0;
         o_addr                   <= 14'h0000;
         o_addr_oe                <= 1'b1;
         o_dm_data_bus            <= 24'h000000;
         o_dm_data_bus_oe         <= 1'b0;
         o_data_space_select_n    <= 1'b1;
         o_program_space_select_n <= 1'b1;
         o_boot_space_select_n    <= 1'b1;
         o_rd_n                   <= 1'b1;
         o_wr_n                   <= 1'b1;
         o_ctl_oe                 <= 1'b1;
         o_hold_acknowledge_n     <= 1'b1;
         o_grant_hang_n           <= 1'b1;
         o_core_ack               <= 1'b0;
         o_core_rdata             <= 16'h0000;
         o_core_run               <= 1'b1;
         o_wait_zone0             <= 3'd7;
         o_go_mode                <= 1'b0;
         if (hold_req) begin
            // Hold is honoured under reset as well.
            state_q              <= ST_GRANT;
            o_addr_oe            <= 1'b0;
            o_ctl_oe             <= 1'b0;
            o_hold_acknowledge_n <= 1'b0;
            o_core_run           <= 1'b0;
         end
      end else begin
         o_core_ack   <= 1'b0;
         o_wait_zone0 <= wait_q[`EBG_WZ0_LSB+2:`EBG_WZ0_LSB];
         o_go_mode    <= sys_q[`EBG_SYS_GO_BIT];
         if (int_req & int_busy_q) begin
            o_core_ack   <= 1'b1;
            o_core_rdata <= is_ram(i_core_addr) ? ram_rdata :
                            (i_core_addr == `EBG_WAIT_REG) ? wait_q :
                            (i_core_addr == `EBG_SYS_REG) ? sys_q : 16'h0000;
         end
         case (state_q)
            ST_IDLE: begin
               if (hold_req) begin
                  // Idle bus: grant in the next cycle.
                  state_q                <= ST_GRANT;
                  o_addr_oe              <= 1'b0;
                  o_dm_data_bus_oe       <= 1'b0;
                  o_ctl_oe               <= 1'b0;
                  o_hold_acknowledge_n   <= 1'b0;
                  o_core_run             <= sys_q[`EBG_SYS_GO_BIT];
               end else if (ext_req & ~o_core_ack) begin
                  state_q               <= ST_EXT;
                  wcnt_q                <= zone_wait;
                  o_addr                <= i_core_addr;
                  o_data_space_select_n <= 1'b0;
                  o_rd_n                <= i_core_wr;
                  o_wr_n                <= ~i_core_wr;
                  o_dm_data_bus         <= {i_core_wdata, 8'h00};
                  o_dm_data_bus_oe      <= i_core_wr;
               end
            end
            ST_EXT: begin
               if (wcnt_q != 3'd0) begin
                  wcnt_q <= wcnt_q - 3'd1;
               end else begin
                  // Access completes; a pending hold is granted two cycles later, after ST_DONE, from ST_IDLE.
                  state_q               <= ST_DONE;
                  o_core_ack            <= 1'b1;
                  o_core_rdata          <= i_dm_data_bus[`EBG_XBUS_W-1:`EBG_DMD_LSB];
                  o_data_space_select_n <= 1'b1;
                  o_rd_n                <= 1'b1;
                  o_wr_n                <= 1'b1;
                  o_dm_data_bus_oe      <= 1'b0;
                  o_grant_hang_n        <= 1'b1;
               end
            end
            ST_DONE: begin
               // One idle cycle lets a hold in between paired accesses.
               state_q <= ST_IDLE;
               if (hold_req | i_core_pair) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               if (!hold_req) begin
                  // Release: drive again and resume where halted.
                  state_q              <= ST_IDLE;
                  o_addr_oe            <= 1'b1;
                  o_ctl_oe             <= 1'b1;
                  o_hold_acknowledge_n <= 1'b1;
                  o_core_run           <= 1'b1;
               end else if (ext_req & ~o_core_ack) begin
                  // Blocked by the grant: stall and flag the hang.
                  o_grant_hang_n <= 1'b0;
                  o_core_run     <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### src/ebg_regs.vh
// Purpose: Constants for the external data memory port and bus grant logic.
// Assumes: Data addresses are 14-bit word addresses.
// Notes:   All values are `define macros used by the design files.
//
// Functional notes
// - Drive 14-bit address every external data access.
// - Data transfers use upper 16 of 24 lines.
// - Assert select, pulse read or write strobe.
// - Peripherals use ordinary memory bus cycles.
// - 2K internal RAM at 0x3000 served inside.
// - 0x3800-0x3FFF are internal control registers.
// - 12K external space, three zones, own waits.
// - All zones reset to seven wait states.
// - Idle hold request: float bus, acknowledge, halt.
// - Go mode runs until external access needed.
// - Hold during access waits until access ends.
// - Grant allowed between two accesses of instruction.
// - Hold released: drop acknowledge, drive, resume.
// - Hold honoured during reset and booting.
// - Grant-hang asserts when access blocked by grant.
// - After return, do access, release grant-hang.
// - Control registers at fixed data addresses.
// - Two extra zone wait fields have no effect.
// - Strobes always qualified by one space select.
`ifndef EBG_REGS_VH
`define EBG_REGS_VH
`define EBG_ADDR_W        14
`define EBG_DATA_W        16
`define EBG_XBUS_W        24
`define EBG_DMD_LSB       8
`define EBG_RAM_BASE      14'h3000
`define EBG_RAM_WORDS     2048
`define EBG_CTRL_BASE     14'h3800
`define EBG_WAIT_REG      14'h3ffe
`define EBG_SYS_REG       14'h3fff
`define EBG_ZONE1_BASE    14'h2000
`define EBG_ZONE2_BASE    14'h2400
`define EBG_WAIT_RESET    16'h7fff
`define EBG_SYS_RESET     16'h0000
`define EBG_WAIT_MASK     16'hffff
`define EBG_SYS_MASK      16'h0008
`define EBG_SYS_GO_BIT    3
`define EBG_WZ0_LSB       0
`define EBG_WZ1_LSB       3
`define EBG_WZ2_LSB       6
`endif

// ### verification/ebg_ext_mem.sv
// Purpose: External data memory and a second bus master.
// Assumes: Writes land on each strobe cycle; reads are combinational.
// Notes:   Unread lines toggle every cycle so a stale value never looks valid.
`timescale 1ns/100ps
`default_nettype none
module ebg_ext_mem (
   input  wire logic        i_core_clk,
   input  wire logic        i_want_bus,
   input  wire logic        i_grant_hang_n,
   input  wire logic        i_data_space_select_n,
   input  wire logic        i_rd_n,
   input  wire logic        i_wr_n,
   input  wire logic        i_ctl_oe,
   input  wire logic [13:0] i_addr,
   input  wire logic [23:0] i_bus,
   output var  logic        o_hold_request_n,
   output wire logic [23:0] o_bus
);
   // ********
   // Model
   // ********
   logic [15:0] mem_q [0:16383];
   logic        junk_q = 1'b0;
   initial o_hold_request_n = 1'b1;
   always @(posedge i_core_clk) begin
      junk_q <= !junk_q;
      o_hold_request_n <= !i_want_bus || !i_grant_hang_n;
      if (!i_data_space_select_n && !i_wr_n && i_ctl_oe) begin
         mem_q[i_addr] <= i_bus[23:8];
      end
   end
   assign o_bus = (!i_data_space_select_n && !i_rd_n && i_ctl_oe) ? {mem_q[i_addr], 8'h00} : {24{junk_q}};
endmodule
`default_nettype wire

// ### verification/ebg_props.sv
// Purpose: Pin timing checks on the data memory port and bus grant logic.
// Assumes: Sees only the ports of ebg_port.
// Notes:   Strobe length is checked for zone 0, the only zone whose wait count is visible.
`timescale 1ns/100ps
`default_nettype none
module ebg_props (
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic        i_core_req,
   input wire logic [13:0] i_core_addr,
   input wire logic        o_core_ack,
   input wire logic        i_hold_request_n,
   input wire logic        o_hold_acknowledge_n,
   input wire logic        o_grant_hang_n,
   input wire logic [13:0] o_addr,
   input wire logic        o_addr_oe,
   input wire logic        o_dm_data_bus_oe,
   input wire logic        o_data_space_select_n,
   input wire logic        o_program_space_select_n,
   input wire logic        o_boot_space_select_n,
   input wire logic        o_rd_n,
   input wire logic        o_wr_n,
   input wire logic        o_ctl_oe,
   input wire logic [2:0]  o_wait_zone0
);
   // ********
   // Checks
   // ********
   logic [3:0] low_cnt_q;
   logic       zone0_q;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // A counter is used because the wait count is not a constant the tools can unroll.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt_q <= 4'h0;
         zone0_q   <= 1'b0;
      end else if (!o_data_space_select_n) begin
         low_cnt_q <= low_cnt_q + 4'h1;
         zone0_q   <= o_addr < 14'h2000;
      end else begin
         low_cnt_q <= 4'h0;
      end
   end
   sequence s_zone0_end;
      $rose(o_data_space_select_n) && zone0_q;
   endsequence
   sequence s_strobe;
      !o_rd_n || !o_wr_n;
   endsequence
   a_strobe_qualified: assert property (
      s_strobe |-> !o_data_space_select_n && o_program_space_select_n && o_boot_space_select_n) else $error("bad select");
   a_wait_length: assert property (
      s_zone0_end |-> low_cnt_q == {1'b0, o_wait_zone0} + 4'h1) else $error("bad strobe length");
   a_grant_floats: assert property (
      !o_hold_acknowledge_n |-> !o_addr_oe && !o_ctl_oe && !o_dm_data_bus_oe) else $error("bus not floated");
   a_no_grant_mid: assert property (
      !o_data_space_select_n |-> o_hold_acknowledge_n) else $error("grant during access");
   a_grant_bound: assert property (
      $fell(i_hold_request_n) |-> ##[1:12] (!o_hold_acknowledge_n || i_hold_request_n)) else $error("grant late");
   a_release_drive: assert property (
      !o_hold_acknowledge_n && i_hold_request_n |=> o_hold_acknowledge_n && o_addr_oe && o_ctl_oe)
      else $error("release late");
   a_hang_raise: assert property (
      !o_hold_acknowledge_n && !i_hold_request_n && i_core_req && i_core_addr < 14'h3000 |=> !o_grant_hang_n)
      else $error("hang missing");
   a_hang_clear: assert property (
      $rose(o_grant_hang_n) |-> o_hold_acknowledge_n && (o_core_ack || $past(o_core_ack))) else $error("hang early");
   a_ram_internal: assert property (
      i_core_req && i_core_addr >= 14'h3000 |=> o_data_space_select_n) else $error("internal went out");
endmodule
bind ebg_port ebg_props u_props (.i_core_clk, .i_rst_n, .i_core_req, .i_core_addr, .o_core_ack,
   .i_hold_request_n, .o_hold_acknowledge_n, .o_grant_hang_n, .o_addr, .o_addr_oe, .o_dm_data_bus_oe,
   .o_data_space_select_n, .o_program_space_select_n, .o_boot_space_select_n, .o_rd_n, .o_wr_n,
   .o_ctl_oe, .o_wait_zone0);
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for ebg_port.
// Assumes: One core request at a time, dropped in the cycle its ack is seen.
// Notes:   Register and memory cases run from a table; grant cases are run by hand before and after it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ********
   // Bench
   // ********
   logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, wr = 1'b0, want = 1'b0;
   logic [13:0] addr = 14'h0000, xaddr;
   logic [15:0] wdata = 16'h0000, rdata;
   logic        ack, run, hreq_n, gnt_n, hang_n, dbus_oe, aoe, coe, dms_n, rd_n, wr_n, go;
   logic [23:0] dout, mbus;
   logic [2:0]  wz0;
   wire  [23:0] dbus = dbus_oe ? dout : mbus;
   integer      fails = 0, n_compared = 0;
   logic [35:0] rows [17] = '{36'h0_3ffe_7fff, 36'h1_0010_a5a5, 36'h0_0010_a5a5, 36'h1_3ffe_7e02,
      36'h0_3ffe_7e02, 36'h1_2000_1234, 36'h0_2000_1234, 36'h1_2fff_beef, 36'h0_2fff_beef, 36'h1_3000_0f0f,
      36'h1_37ff_f0f0, 36'h0_3000_0f0f, 36'h0_37ff_f0f0, 36'h1_3800_ffff, 36'h0_3800_0000, 36'h1_3fff_0008,
      36'h0_3fff_0008};
   always #10 clk = ~clk;
   ebg_port dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_core_req(req), .i_core_wr(wr), .i_core_addr(addr),
      .i_core_wdata(wdata), .i_core_pair(1'b0), .o_core_ack(ack), .o_core_rdata(rdata), .o_core_run(run),
      .i_hold_request_n(hreq_n), .o_hold_acknowledge_n(gnt_n), .o_grant_hang_n(hang_n), .o_addr(xaddr),
      .o_addr_oe(aoe), .i_dm_data_bus(dbus), .o_dm_data_bus(dout), .o_dm_data_bus_oe(dbus_oe),
      .o_data_space_select_n(dms_n), .o_program_space_select_n(), .o_boot_space_select_n(),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ctl_oe(coe), .o_wait_zone0(wz0), .o_go_mode(go));
   ebg_ext_mem mem (.i_core_clk(clk), .i_want_bus(want), .i_grant_hang_n(hang_n), .i_data_space_select_n(dms_n),
      .i_rd_n(rd_n), .i_wr_n(wr_n), .i_ctl_oe(coe), .i_addr(xaddr), .i_bus(dbus), .o_hold_request_n(hreq_n),
      .o_bus(mbus));
   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // The request stands until the rising edge at which ack is seen high, then is dropped there.
   task automatic acc(input logic w, input logic [13:0] a, input logic [15:0] d, output logic [15:0] q);
      integer k;
      @(posedge clk);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      q = rdata;
      req <= 1'b0;
      if (k == 40) begin
         chk("ack", 16'h0001, 16'h0000);
         wrap_up();
      end
   endtask
   initial begin : main
      logic [15:0] q;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      want <= 1'b1;
      repeat (4) @(negedge clk);
      chk("grant", 16'h0000, {11'h000, aoe, coe, dbus_oe, run, gnt_n});
      @(posedge clk);
      want <= 1'b0;
      repeat (3) @(negedge clk);
      chk("release", 16'h001b, {11'h000, aoe, coe, dbus_oe, run, gnt_n});
      for (int i = 0; i < 17; i++) begin
         acc(rows[i][32], rows[i][29:16], rows[i][15:0], q);
         if (!rows[i][32]) chk("read", rows[i][15:0], q);
      end
      chk("cfg", 16'h000a, {12'h000, go, wz0});
      fork
         acc(1'b0, 14'h0010, 16'h0000, q);
         begin
            @(posedge clk);
            want <= 1'b1;
         end
      join
      chk("read", 16'ha5a5, q);
      repeat (3) @(negedge clk);
      chk("go grant", 16'h0002, {14'h0000, run, gnt_n});
      acc(1'b0, 14'h0010, 16'h0000, q);
      chk("hang read", 16'ha5a5, q);
      @(negedge clk);
      chk("hang", 16'h0001, {15'h0000, hang_n});
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk("grant in reset", 16'h0000, {15'h0000, gnt_n});
      rst_n <= 1'b1;
      repeat (3) @(negedge clk);
      chk("reset grant", 16'h0007, {12'h000, gnt_n, wz0});
      @(posedge clk);
      want <= 1'b0;
      repeat (3) @(negedge clk);
      wrap_up();
   end
endmodule
`default_nettype wire
